// ### src/tmh_setup.sv
// multichannel slot controller: register file, slot table walk, channel setup and event logging
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
`include "tmh_consts.svh"
module tmh_setup
   import tmh_pkg::*;
#(
   parameter bit NARROW_CP = 1'b0
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   input  wire logic        rx_pin,
   output logic             tx_pin,
   output logic             slot_valid,
   output logic [7:0]       slot_data,
   output logic [5:0]       slot_chan,
   output logic [11:0]      chan_param_addr,
   output logic [31:0]      rx_desc_addr,
   output logic             tx_desc_req,
   output logic [31:0]      tx_desc_addr,
   output logic             event_wr,
   output logic [31:0]      event_addr,
   output logic [15:0]      event_word
);
   logic [31:0] gml_q, desc_base_q, evt_base_q, evt_cur_q, max_rxlen_q;
   logic [31:0] frm_thr_q, frm_cnt_q, crc32_q, crc16_q, ctrl_st_q, rdata_q;
   logic [3:0]  ser_ev_q, ser_mask_q, ser_set;
   logic [4:0]  slot_cur_q;
   tmh_word16_t slot_tab_q [32];
   tmh_word16_t ch_mode_q [64];
   tmh_word16_t ch_mask_q [64];
   tmh_word16_t rx_base_q [64];
   tmh_word16_t tx_base_q [64];
   tmh_word16_t rx_cur_q [64];
   tmh_word16_t tx_cur_q [64];
   tmh_run_t    run_st;
   logic        glob_sel, slot_sel, ch_sel, cur_wr, ser_wr;
   logic [5:0]  wch, ch;
   logic [2:0]  wfld;
   tmh_word16_t tx_enable, cm;
   logic        bit_tick, slot_done, tx_q, tx_bit, hdlc;
   logic [2:0]  bit_pos;
   logic [7:0]  sh_byte;
   logic [1:0]  ev_bits, ev_hit;
   logic        sv_q, treq_q, ewr_q;
   logic [7:0]  sd_q;
   logic [5:0]  sc_q;
   logic [11:0] pa_q;
   logic [31:0] rda_q, tda_q, ea_q;
   logic [15:0] ew_q;
   localparam logic [7:0] FLAG_PAT = `TMH_FLAG_BYTE;

   function automatic logic glob_hit(input logic [11:0] a, input logic [11:0] ofs);
      glob_hit = (a == ofs);
   endfunction

   assign glob_sel = (addr[11:8] == 4'h0);
   assign slot_sel = (addr[11:10] == `TMH_SLOT_AREA);
   assign ch_sel   = (addr[11] == `TMH_CH_AREA);
   assign wch      = addr[10:5];
   assign wfld     = addr[4:2];
   assign cur_wr   = wr && glob_hit(addr, `TMH_OFS_SLOT_CUR);
   assign ser_wr   = wr && glob_hit(addr, `TMH_OFS_SER_EV);

   // run only in multichannel mode with the receiver enabled
   assign run_st = (gml_q[3:0] == `TMH_MULTI_MODE && gml_q[`TMH_GML_RXEN]) ? TMH_RUN : TMH_IDLE;
   assign tx_enable = slot_tab_q[slot_cur_q];
   assign ch  = {tx_enable[13] & ~NARROW_CP, tx_enable[12:8]};
   assign cm  = ch_mode_q[ch];
   assign hdlc = cm[`TMH_CM_HDLC];

   always_ff @(posedge clock) begin
      if (rst) begin
         gml_q <= 32'h0; desc_base_q <= 32'h0; evt_base_q <= 32'h0; max_rxlen_q <= 32'h0;
         frm_thr_q <= 32'h0; frm_cnt_q <= 32'h0; crc32_q <= 32'h0; crc16_q <= 32'h0;
         ctrl_st_q <= 32'h0; ser_mask_q <= 4'h0;
      end else if (wr && glob_sel) begin
         unique case (addr)
            `TMH_OFS_GML:       gml_q       <= wdata;
            `TMH_OFS_DESC_BASE: desc_base_q <= {wdata[31:16], 16'h0000};
            `TMH_OFS_EVT_BASE:  evt_base_q  <= wdata;
            `TMH_OFS_MAX_RXLEN: max_rxlen_q <= wdata;
            `TMH_OFS_FRM_THR:   frm_thr_q   <= wdata;
            `TMH_OFS_FRM_CNT:   frm_cnt_q   <= wdata;
            `TMH_OFS_CRC32:     crc32_q     <= wdata;
            `TMH_OFS_CRC16:     crc16_q     <= {16'h0000, wdata[15:0]};
            `TMH_OFS_CTRL_ST:   ctrl_st_q   <= {16'h0000, wdata[15:0]};
            `TMH_OFS_SER_MASK:  ser_mask_q  <= wdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 32; i++) begin
            slot_tab_q[i] <= 16'h0000;
         end
      end else if (wr && slot_sel) begin
         slot_tab_q[addr[6:2]] <= wdata[15:0];
      end
   end

   // channel words; a software write to the mode word beats the hardware poll clear
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 64; i++) begin
            ch_mode_q[i] <= 16'h0000; ch_mask_q[i] <= 16'h0000;
            rx_base_q[i] <= 16'h0000; tx_base_q[i] <= 16'h0000;
            rx_cur_q[i]  <= 16'h0000; tx_cur_q[i]  <= 16'h0000;
         end
      end else begin
         if (slot_done && run_st == TMH_RUN && tx_enable[`TMH_ENT_VALID] && cm[`TMH_CM_POLL]) begin
            ch_mode_q[ch][`TMH_CM_POLL] <= 1'b0;
         end
         if (wr && ch_sel) begin
            unique case (wfld)
               `TMH_FLD_MODE:   ch_mode_q[wch] <= wdata[15:0];
               `TMH_FLD_EVMASK: ch_mask_q[wch] <= wdata[15:0];
               `TMH_FLD_RXBASE: rx_base_q[wch] <= wdata[15:0];
               `TMH_FLD_TXBASE: tx_base_q[wch] <= wdata[15:0];
               `TMH_FLD_RXCUR:  rx_cur_q[wch]  <= wdata[15:0];
               `TMH_FLD_TXCUR:  tx_cur_q[wch]  <= wdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // slot walk: wrap entry sends the cursor back to the table start
   always_ff @(posedge clock) begin
      if (rst) begin
         slot_cur_q <= 5'h00;
      end else if (cur_wr) begin
         slot_cur_q <= wdata[4:0];
      end else if (slot_done && run_st == TMH_RUN) begin
         slot_cur_q <= tx_enable[`TMH_ENT_WRAP] ? 5'h00 : slot_cur_q + 5'h01;
      end
   end

   tmh_slot_shifter u_shift (
      .clock     (clock),
      .rst       (rst),
      .run       (run_st == TMH_RUN),
      .rx_pin    (rx_pin),
      .mask      (tx_enable[7:0]),
      .reverse   (!hdlc && cm[`TMH_CM_REV_IDLE]),
      .bit_tick  (bit_tick),
      .bit_pos   (bit_pos),
      .slot_done (slot_done),
      .slot_byte (sh_byte)
   );

   // transmit: flags or ones as idle fill in HDLC, ones in transparent
   always_comb begin
      tx_bit = 1'b1;
      if (gml_q[`TMH_GML_TXEN] && tx_enable[`TMH_ENT_VALID] && tx_enable[bit_pos] && cm[`TMH_CM_TXEN] && hdlc &&
          !cm[`TMH_CM_REV_IDLE]) begin
         tx_bit = FLAG_PAT[bit_pos];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_q <= 1'b1;
      end else if (run_st != TMH_RUN) begin
         // a stopped engine must not leave a flag zero standing on the line
         tx_q <= 1'b1;
      end else if (bit_tick) begin
         tx_q <= tx_bit;
      end
   end

   assign ev_bits = {cm[`TMH_CM_POLL], 1'b1};
   assign ev_hit  = ev_bits & ch_mask_q[ch][1:0];

   always_ff @(posedge clock) begin
      if (rst) begin
         sv_q <= 1'b0; treq_q <= 1'b0; ewr_q <= 1'b0; sd_q <= 8'h00; sc_q <= 6'h00;
         pa_q <= 12'h000; rda_q <= 32'h0; tda_q <= 32'h0; ea_q <= 32'h0; ew_q <= 16'h0000;
      end else begin
         sv_q   <= 1'b0;
         treq_q <= 1'b0;
         ewr_q  <= 1'b0;
         if (slot_done && run_st == TMH_RUN && tx_enable[`TMH_ENT_VALID]) begin
            sv_q   <= 1'b1;
            sd_q   <= sh_byte;
            sc_q   <= ch;
            pa_q   <= {ch, 6'h00};
            rda_q  <= desc_base_q + {16'h0000, rx_cur_q[ch]};
            treq_q <= cm[`TMH_CM_POLL];
            tda_q  <= desc_base_q + {16'h0000, tx_cur_q[ch]};
            ewr_q  <= (ev_hit != 2'b00);
            ea_q   <= evt_cur_q;
            ew_q   <= {2'b10, 4'h0, ch, 2'b00, ev_hit};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         evt_cur_q <= 32'h0;
      end else if (wr && glob_hit(addr, `TMH_OFS_EVT_CUR)) begin
         evt_cur_q <= wdata;
      end else if (ewr_q) begin
         evt_cur_q <= evt_cur_q + 32'h2;
      end
   end

   assign ser_set = {sv_q, treq_q, slot_done && run_st == TMH_RUN && !tx_enable[`TMH_ENT_VALID], ewr_q};

   // write one clears, a new event in the same cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         ser_ev_q <= 4'h0;
      end else begin
         ser_ev_q <= (ser_ev_q & ~(ser_wr ? wdata[3:0] : 4'h0)) | ser_set;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= 32'h0;
         if (rd && slot_sel) begin
            rdata_q <= {16'h0000, slot_tab_q[addr[6:2]]};
         end else if (rd && ch_sel) begin
            unique case (wfld)
               `TMH_FLD_MODE:   rdata_q <= {16'h0000, ch_mode_q[wch]};
               `TMH_FLD_EVMASK: rdata_q <= {16'h0000, ch_mask_q[wch]};
               `TMH_FLD_RXBASE: rdata_q <= {16'h0000, rx_base_q[wch]};
               `TMH_FLD_TXBASE: rdata_q <= {16'h0000, tx_base_q[wch]};
               `TMH_FLD_RXCUR:  rdata_q <= {16'h0000, rx_cur_q[wch]};
               `TMH_FLD_TXCUR:  rdata_q <= {16'h0000, tx_cur_q[wch]};
               default: ;
            endcase
         end else if (rd && glob_sel) begin
            unique case (addr)
               `TMH_OFS_GML:       rdata_q <= gml_q;
               `TMH_OFS_DESC_BASE: rdata_q <= desc_base_q;
               `TMH_OFS_EVT_BASE:  rdata_q <= evt_base_q;
               `TMH_OFS_EVT_CUR:   rdata_q <= evt_cur_q;
               `TMH_OFS_MAX_RXLEN: rdata_q <= max_rxlen_q;
               `TMH_OFS_FRM_THR:   rdata_q <= frm_thr_q;
               `TMH_OFS_FRM_CNT:   rdata_q <= frm_cnt_q;
               `TMH_OFS_CRC32:     rdata_q <= crc32_q;
               `TMH_OFS_CRC16:     rdata_q <= crc16_q;
               `TMH_OFS_CTRL_ST:   rdata_q <= ctrl_st_q;
               `TMH_OFS_SER_EV:    rdata_q <= {28'h0, ser_ev_q};
               `TMH_OFS_SER_MASK:  rdata_q <= {28'h0, ser_mask_q};
               `TMH_OFS_SLOT_CUR:  rdata_q <= {27'h0, slot_cur_q};
               default: ;
            endcase
         end
      end
   end

   assign rdata = rdata_q;
   assign tx_pin = tx_q;
   assign slot_valid = sv_q;
   assign slot_data = sd_q;
   assign slot_chan = sc_q;
   assign chan_param_addr = pa_q;
   assign rx_desc_addr = rda_q;
   assign tx_desc_req = treq_q;
   assign tx_desc_addr = tda_q;
   assign event_wr = ewr_q;
   assign event_addr = ea_q;
   assign event_word = ew_q;

   a_mode_gate: assert property (@(posedge clock) disable iff (rst)
      sv_q |-> $past(gml_q[3:0]) == 4'ha && $past(gml_q[`TMH_GML_RXEN])) else $error("slot output outside mode");
   a_desc_addr: assert property (@(posedge clock) disable iff (rst)
      sv_q |-> rda_q[31:16] == $past(desc_base_q[31:16]) && rda_q[15:0] == $past(rx_cur_q[ch]))
      else $error("bad rx descriptor address");
   a_wrap_return: assert property (@(posedge clock) disable iff (rst)
      slot_done && run_st == TMH_RUN && tx_enable[`TMH_ENT_WRAP] && !cur_wr |=> slot_cur_q == 5'h00)
      else $error("wrap did not return");
   a_valid_only: assert property (@(posedge clock) disable iff (rst)
      slot_done && run_st == TMH_RUN && !tx_enable[`TMH_ENT_VALID] |=> !sv_q && ser_ev_q[`TMH_SE_INVALID])
      else $error("invalid entry used");
   a_mask_zero: assert property (@(posedge clock) disable iff (rst)
      slot_done && run_st == TMH_RUN && tx_enable[`TMH_ENT_VALID] && tx_enable[7:0] == 8'h00 |=> sd_q == 8'h00)
      else $error("masked bits leaked");
   a_param_addr: assert property (@(posedge clock) disable iff (rst)
      pa_q[5:0] == 6'h00 && !(NARROW_CP && pa_q[11])) else $error("bad parameter address");
   a_event_mask: assert property (@(posedge clock) disable iff (rst)
      ewr_q |-> (ew_q[1:0] & ~$past(ch_mask_q[ch][1:0])) == 2'b00 && ew_q[1:0] != 2'b00 ##1
      ser_ev_q[`TMH_SE_LOGGED]) else $error("unmasked event logged");
   a_flag_fill: assert property (@(posedge clock) disable iff (rst)
      bit_tick && gml_q[`TMH_GML_TXEN] && tx_enable[`TMH_ENT_VALID] && tx_enable[bit_pos] && cm[`TMH_CM_TXEN] && hdlc &&
      !cm[`TMH_CM_REV_IDLE] |=> tx_q == $past(FLAG_PAT[bit_pos])) else $error("flag fill wrong");
   a_w1c_keep: assert property (@(posedge clock) disable iff (rst)
      ser_wr && !wdata[0] && ser_ev_q[0] |=> ser_ev_q[0]) else $error("event bit lost on zero write");
endmodule
`default_nettype wire

// ### src/tmh_consts.svh
// register offsets, field positions, flag byte and timing counts of the slot engine
`ifndef TMH_CONSTS_SVH
`define TMH_CONSTS_SVH
`define TMH_ADDR_W        12
`define TMH_OFS_GML       12'h000
`define TMH_OFS_DESC_BASE 12'h004
`define TMH_OFS_EVT_BASE  12'h008
`define TMH_OFS_EVT_CUR   12'h00c
`define TMH_OFS_MAX_RXLEN 12'h010
`define TMH_OFS_FRM_THR   12'h014
`define TMH_OFS_FRM_CNT   12'h018
`define TMH_OFS_CRC32     12'h01c
`define TMH_OFS_CRC16     12'h020
`define TMH_OFS_CTRL_ST   12'h024
`define TMH_OFS_SER_EV    12'h028
`define TMH_OFS_SER_MASK  12'h02c
`define TMH_OFS_SLOT_CUR  12'h030
`define TMH_SLOT_AREA     2'b01
`define TMH_CH_AREA       1'b1
`define TMH_FLD_MODE      3'h0
`define TMH_FLD_EVMASK    3'h1
`define TMH_FLD_RXBASE    3'h2
`define TMH_FLD_TXBASE    3'h3
`define TMH_FLD_RXCUR     3'h4
`define TMH_FLD_TXCUR     3'h5
`define TMH_MULTI_MODE    4'ha
`define TMH_GML_TXEN      4
`define TMH_GML_RXEN      5
`define TMH_ENT_VALID     15
`define TMH_ENT_WRAP      14
`define TMH_CM_HDLC       15
`define TMH_CM_REV_IDLE   14
`define TMH_CM_TXEN       13
`define TMH_CM_SYNC       12
`define TMH_CM_POLL       11
`define TMH_CM_CRC        10
`define TMH_EV_SLOT       0
`define TMH_EV_POLL       1
`define TMH_SE_LOGGED     0
`define TMH_SE_INVALID    1
`define TMH_SE_TXREQ      2
`define TMH_SE_RXBYTE     3
`define TMH_FLAG_BYTE     8'h7e
`define TMH_BIT_NS        400
`define TMH_CLK_NS        100
`define TMH_BIT_DIV       ((`TMH_BIT_NS + `TMH_CLK_NS - 1) / `TMH_CLK_NS)
`endif

// ### src/tmh_pkg.sv
// types shared by the slot engine modules
`default_nettype none
package tmh_pkg;
   typedef enum logic [0:0] {
      TMH_IDLE = 1'b0,
      TMH_RUN  = 1'b1
   } tmh_run_t;
   typedef logic [15:0] tmh_word16_t;
endpackage
`default_nettype wire

// ### src/tmh_slot_shifter.sv
// bit divider, pin synchroniser and masked bit collector for one time slot
`default_nettype none
`include "tmh_consts.svh"
module tmh_slot_shifter
   import tmh_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic       rx_pin,
   input  wire logic [7:0] mask,
   input  wire logic       reverse,
   output logic            bit_tick,
   output logic [2:0]      bit_pos,
   output logic            slot_done,
   output logic [7:0]      slot_byte
);
   localparam logic [3:0] DIV = 4'(`TMH_BIT_DIV);
   logic       sync1_q;
   logic       sync2_q;
   logic [3:0] div_q;
   logic [2:0] pos_q;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic       done_q;
   logic [7:0] byte_q;

   function automatic logic [7:0] bit_rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         bit_rev[i] = v[7 - i];
      end
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= rx_pin;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !run) begin
         div_q <= 4'h0;
      end else if (div_q == DIV - 4'h1) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   assign bit_tick = run && (div_q == DIV - 4'h1);
   assign bit_pos  = pos_q;

   // only masked bit positions enter the collected byte
   always_comb begin
      acc_d = acc_q;
      if (mask[pos_q]) begin
         acc_d = {acc_q[6:0], sync2_q};
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !run) begin
         pos_q  <= 3'h0;
         acc_q  <= 8'h00;
         done_q <= 1'b0;
         byte_q <= 8'h00;
      end else begin
         done_q <= bit_tick && (pos_q == 3'h7);
         if (bit_tick) begin
            pos_q <= pos_q + 3'h1;
            if (pos_q == 3'h7) begin
               acc_q  <= 8'h00;
               byte_q <= reverse ? bit_rev(acc_d) : acc_d;
            end else begin
               acc_q <= acc_d;
            end
         end
      end
   end

   assign slot_done = done_q;
   assign slot_byte = byte_q;
endmodule
`default_nettype wire

// ### testbench/tmh_line_model.sv
// tdm line model: steady receive fill level and a count of clocks with the transmit line low
`default_nettype none
module tmh_line_model
   import tmh_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   rst,
   input  wire logic   fill,
   input  wire logic   clear,
   input  wire logic   tx_pin,
   output logic        rx_pin,
   output logic [15:0] zeros_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // a constant level makes the collected bits independent of the bit phase
   assign rx_pin = fill;

   always_ff @(posedge clock) begin
      if (rst || clear) begin
         zeros_seen <= 16'h0;
      end else if (tx_pin === 1'b0) begin
         zeros_seen <= zeros_seen + 16'h1;
      end
   end
endmodule
`default_nettype wire

// ### testbench/tmh_setup_tb.sv
// self-checking bench for the multichannel slot controller
`default_nettype none
module tmh_setup_tb
   import tmh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst, wr, rd, rx_pin, tx_pin, slot_valid, tx_desc_req, event_wr, fill, clear;
   logic [11:0] addr, chan_param_addr;
   logic [31:0] wdata, rdata, rx_desc_addr, tx_desc_addr, event_addr;
   logic [7:0]  slot_data;
   logic [5:0]  slot_chan;
   logic [15:0] event_word, zeros_seen;
   logic [31:0] sq[$], rq[$], eq[$], tq[$];
   int          fails, checks;

   tmh_setup #(.NARROW_CP(1'b0)) uut (
      .clock          (clock),
      .rst            (rst),
      .addr           (addr),
      .wdata          (wdata),
      .wr             (wr),
      .rd             (rd),
      .rdata          (rdata),
      .rx_pin         (rx_pin),
      .tx_pin         (tx_pin),
      .slot_valid     (slot_valid),
      .slot_data      (slot_data),
      .slot_chan      (slot_chan),
      .chan_param_addr(chan_param_addr),
      .rx_desc_addr   (rx_desc_addr),
      .tx_desc_req    (tx_desc_req),
      .tx_desc_addr   (tx_desc_addr),
      .event_wr       (event_wr),
      .event_addr     (event_addr),
      .event_word     (event_word)
   );

   tmh_line_model line (
      .clock     (clock),
      .rst       (rst),
      .fill      (fill),
      .clear     (clear),
      .tx_pin    (tx_pin),
      .rx_pin    (rx_pin),
      .zeros_seen(zeros_seen)
   );

   initial clock = 1'b0;
   always #50 clock = ~clock;

   // records every pulse output: {chan, data, param addr}, descriptor and event addresses
   always @(posedge clock) begin
      if (slot_valid === 1'b1) begin
         sq.push_back({6'h0, slot_chan, slot_data, chan_param_addr});
         rq.push_back(rx_desc_addr);
      end
      if (event_wr === 1'b1) begin
         eq.push_back({event_addr[15:0], event_word});
      end
      if (tx_desc_req === 1'b1) begin
         tq.push_back(tx_desc_addr);
      end
   end

   task automatic wrap_up();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic wait_q(input int n);
      int k;
      k = 0;
      while (sq.size() < n) begin
         @(negedge clock);
         k++;
         if (k > 200 * n) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, sq.size(), n);
            wrap_up();
         end
      end
   endtask

   task automatic halt();
      wreg(12'h000, 32'h0);
      repeat (40) @(posedge clock);
   endtask

   // stops the engine, rewinds the slot cursor, then enables as the last step
   task automatic run(input logic [31:0] gml);
      halt();
      wreg(12'h030, 32'h0);
      sq.delete();
      rq.delete();
      eq.delete();
      tq.delete();
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      wreg(12'h000, gml);
   endtask

   task automatic t_reset();
      rchk(12'h028, 32'h0);
      rchk(12'h000, 32'h0);
      rchk(12'hffc, 32'h0);
      // channel state words are kept outside the block, so their slots stay unmapped
      wreg(12'h878, 32'h38000000);
      rchk(12'h878, 32'h0);
      wreg(12'h87c, 32'h100);
      rchk(12'h87c, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_regs();
      wreg(12'h01c, 32'hdebb20e3);
      wreg(12'h020, 32'hdeadf0b8);
      wreg(12'h004, 32'h00012345);
      wreg(12'h024, 32'h00008000);
      wreg(12'h014, 32'h1);
      wreg(12'h018, 32'h1);
      wreg(12'h010, 32'h3c);
      wreg(12'h860, 32'h8c07);
      rchk(12'h01c, 32'hdebb20e3);
      rchk(12'h020, 32'h0000f0b8);
      rchk(12'h004, 32'h00010000);
      rchk(12'h024, 32'h00008000);
      rchk(12'h018, 32'h1);
      rchk(12'h010, 32'h3c);
      rchk(12'h860, 32'h8c07);
      $display("test registers done");
   endtask

   task automatic t_mode();
      wreg(12'h860, 32'h0);
      wreg(12'h868, 32'h30);
      wreg(12'h870, 32'h30);
      wreg(12'h400, 32'hc3ff);
      run(32'h29);
      repeat (150) @(posedge clock);
      chk(sq.size(), 0);
      run(32'h2a);
      wait_q(2);
      chk(sq[0], {6'h0, 6'h03, 8'hff, 12'h0c0});
      chk(sq[1][25:20], 6'h03);
      chk(rq[0], 32'h00010030);
      chk(rq[1], 32'h00010030);
      $display("test mode done");
   endtask

   task automatic t_mask();
      wreg(12'h400, 32'hc30f);
      run(32'h2a);
      wait_q(1);
      chk(sq[0][19:12], 8'h0f);
      wreg(12'h860, 32'h4000);
      run(32'h2a);
      wait_q(1);
      chk(sq[0][19:12], 8'hf0);
      wreg(12'h860, 32'h0);
      @(posedge clock);
      fill <= 1'b0;
      wreg(12'h400, 32'hc3ff);
      run(32'h2a);
      wait_q(1);
      chk(sq[0][19:12], 8'h00);
      @(posedge clock);
      fill <= 1'b1;
      $display("test mask done");
   endtask

   task automatic t_walk();
      wreg(12'h400, 32'h01ff);
      wreg(12'h404, 32'h82ff);
      wreg(12'h408, 32'hc5ff);
      wreg(12'h028, 32'hf);
      run(32'h2a);
      wait_q(3);
      chk(sq[0][25:20], 6'h02);
      chk(sq[1][25:20], 6'h05);
      chk(sq[2][25:20], 6'h02);
      halt();
      rchk(12'h028, 32'ha);
      wreg(12'h028, 32'h0);
      rchk(12'h028, 32'ha);
      wreg(12'h028, 32'h2);
      rchk(12'h028, 32'h8);
      $display("test walk done");
   endtask

   task automatic t_events();
      wreg(12'h400, 32'hc3ff);
      wreg(12'h008, 32'hf000);
      wreg(12'h00c, 32'hf000);
      run(32'h2a);
      wait_q(2);
      chk(eq.size(), 0);
      wreg(12'h864, 32'h1);
      run(32'h2a);
      wait_q(2);
      halt();
      chk(eq[0], 32'hf0008031);
      chk(eq[1], 32'hf0028031);
      rchk(12'h00c, 32'hf000 + 2 * eq.size());
      $display("test events done");
   endtask

   task automatic t_poll();
      wreg(12'h86c, 32'h38);
      wreg(12'h874, 32'h38);
      wreg(12'h864, 32'h0);
      wreg(12'h860, 32'h8800);
      run(32'h3a);
      wait_q(2);
      chk(tq.size(), 1);
      chk(tq[0], 32'h00010038);
      chk(zeros_seen, 32'h0);
      rchk(12'h860, 32'h8000);
      rchk(12'h874, 32'h38);
      wreg(12'h860, 32'ha000);
      run(32'h3a);
      wait_q(2);
      chk({31'h0, zeros_seen > 16'h0}, 32'h1);
      halt();
      chk(tx_pin, 1'b1);
      $display("test poll done");
   endtask

   initial begin
      rst   = 1'b1;
      addr  = 12'h0;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
      fill  = 1'b1;
      clear = 1'b0;
      fails = 0;
      checks = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_mode();
      t_mask();
      t_walk();
      t_events();
      t_poll();
      wrap_up();
   end
endmodule
`default_nettype wire
